// file: rtl/adc_seq_params.svh
`ifndef ADC_SEQ_PARAMS_SVH
`define ADC_SEQ_PARAMS_SVH

// Widths
`define RESULT_W 12
`define CNT_W 17
`define PIN_W 7

// Sequence lengths in master clock periods
// 18
`define CONV_PERIODS 17'h0_0012
// 125013
`define CAL_FULL_PERIODS 17'h1_E855
// 111124
`define CAL_DAC_FS_PERIODS 17'h1_B214
// 13889
`define CAL_OFFSET_PERIODS 17'h0_3641

// Idle levels of the pin group: both active-low strobes high
`define PIN_RESET_VALUE 7'h06

`endif

// file: rtl/adc_seq_pkg.sv
`include "adc_seq_params.svh"

package adc_seq_pkg;

  typedef enum logic [1:0] {
    JOB_CONV = 2'h0,
    JOB_CAL_FULL = 2'h1,
    JOB_CAL_DAC_FS = 2'h2,
    JOB_CAL_OFFSET = 2'h3
  } job_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_COUNT = 4'h2,
    ST_LATCH = 4'h4,
    ST_FINISH = 4'h8
  } seq_state_t;

  typedef struct packed {
    job_t cal_mode;
    logic pm_lo;
    logic pm_hi;
    logic cs_n;
    logic start_n;
    logic mclk;
  } pins_t;

  typedef struct packed {
    seq_state_t state;
    job_t job;
    logic [`CNT_W-1:0] cnt;
    logic busy;
    logic [`RESULT_W-1:0] sample;
    logic [`RESULT_W-1:0] result;
    logic full_pd;
    logic part_pd;
  } seq_t;

endpackage

// file: rtl/pin_sync.sv
`timescale 1ns/10ps

module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RESET_VALUE = '0
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Pins
  input wire logic [W-1:0] pin_in,
  // Filtered levels and edges
  output logic [W-1:0] level_out,
  output logic [W-1:0] rise_out,
  output logic [W-1:0] fall_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] level;
  } sync_t;

  sync_t s;
  sync_t next_s;
  logic [W-1:0] agree;

  // A change counts once the second and third stages agree
  assign agree = ~(s.s2 ^ s.s3);
  assign level_out = s.level;
  assign rise_out = agree & s.s3 & ~s.level;
  assign fall_out = agree & ~s.s3 & s.level;

  always_comb begin
    next_s = s;
    next_s.s1 = pin_in;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    next_s.level = (agree & s.s3) | (~agree & s.level);
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= {RESET_VALUE, RESET_VALUE, RESET_VALUE, RESET_VALUE};
    end else begin
      s <= next_s;
    end
  end

endmodule

// file: rtl/adc_sequencer.sv
// Contract
// RQ1: A conversion lasts exactly 18 master clock periods, start to end.
// RQ2: Full self-calibration lasts 125013 master clock periods.
// RQ3: Internal DAC plus system full-scale calibration lasts 111124 periods.
// RQ4: System offset calibration lasts 13889 master clock periods.
// RQ5: In calibration, busy rises within 2.5 periods of chip select rising.
// RQ6: New result is valid half a master period before busy falls.
// RQ7: An asserted conversion start pulse raises busy; in full power-down the code ignores it.
// RQ8: Power bits 1,0 give full power-down; 1,1 give partial power-down.
// RQ9: Busy stays high for the whole sequence and falls only at its end.
`timescale 1ns/10ps

module adc_sequencer
  import adc_seq_pkg::*;
#(
  parameter logic [`CNT_W-1:0] CONV_PERIODS = `CONV_PERIODS,
  parameter logic [`CNT_W-1:0] CAL_FULL_PERIODS = `CAL_FULL_PERIODS,
  parameter logic [`CNT_W-1:0] CAL_DAC_FS_PERIODS = `CAL_DAC_FS_PERIODS,
  parameter logic [`CNT_W-1:0] CAL_OFFSET_PERIODS = `CAL_OFFSET_PERIODS
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Host and board pins
  input wire logic master_clock_in,
  input wire logic conversion_start_n_in,
  input wire logic chip_select_n_in,
  input wire job_t cal_mode_in,
  input wire logic power_mgmt_bit_hi_in,
  input wire logic power_mgmt_bit_lo_in,
  // Converter core
  input wire logic [`RESULT_W-1:0] sample_in,
  // Status
  output logic busy_out,
  output logic [`RESULT_W-1:0] result_out,
  output logic full_power_down_out,
  output logic partial_power_down_out
);

  seq_t s;
  seq_t next_s;
  pins_t pins_raw;
  pins_t pins;
  pins_t pins_rise;
  pins_t pins_fall;
  logic [`PIN_W-1:0] level_vec;
  logic [`PIN_W-1:0] rise_vec;
  logic [`PIN_W-1:0] fall_vec;
  logic mclk_rise;
  logic mclk_fall;
  logic start_req;
  logic cal_req;
  logic [`CNT_W-1:0] rise_count;

  function automatic logic [`CNT_W-1:0] target_of(input job_t j);
    logic [`CNT_W-1:0] t;
    t = CONV_PERIODS;
    unique case (j)
      JOB_CONV: t = CONV_PERIODS;
      JOB_CAL_FULL: t = CAL_FULL_PERIODS;
      JOB_CAL_DAC_FS: t = CAL_DAC_FS_PERIODS;
      JOB_CAL_OFFSET: t = CAL_OFFSET_PERIODS;
    endcase
    return t;
  endfunction

  assign pins_raw.cal_mode = cal_mode_in;
  assign pins_raw.pm_lo = power_mgmt_bit_lo_in;
  assign pins_raw.pm_hi = power_mgmt_bit_hi_in;
  assign pins_raw.cs_n = chip_select_n_in;
  assign pins_raw.start_n = conversion_start_n_in;
  assign pins_raw.mclk = master_clock_in;

  pin_sync #(
    .W(`PIN_W),
    .RESET_VALUE(`PIN_RESET_VALUE)
  ) u_pin_sync (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .pin_in(pins_raw),
    .level_out(level_vec),
    .rise_out(rise_vec),
    .fall_out(fall_vec)
  );

  assign pins = level_vec;
  assign pins_rise = rise_vec;
  assign pins_fall = fall_vec;
  assign mclk_rise = pins_rise.mclk;
  assign mclk_fall = pins_fall.mclk;

  // Full power-down refuses new work; partial power-down still wakes
  assign start_req = pins_fall.start_n && !s.full_pd;
  assign cal_req = pins_rise.cs_n && (pins.cal_mode != JOB_CONV) &&
                   !s.full_pd;

  always_comb begin
    next_s = s;
    next_s.full_pd = pins.pm_hi && !pins.pm_lo; // [RQ8]
    next_s.part_pd = pins.pm_hi && pins.pm_lo; // [RQ8]
    unique case (s.state)
      ST_IDLE: begin
        if (start_req) begin
          // Conversion takes precedence over a calibration request
          next_s.job = JOB_CONV;
          next_s.sample = sample_in;
          next_s.busy = 1'b1; // [RQ7]
          next_s.cnt = '0;
          next_s.state = ST_COUNT;
        end else if (cal_req) begin
          next_s.job = pins.cal_mode;
          next_s.busy = 1'b1; // [RQ5]
          next_s.cnt = '0;
          next_s.state = ST_COUNT;
        end
      end
      ST_COUNT: begin
        if (mclk_rise) begin
          next_s.cnt = s.cnt + 1'b1;
          // Stop one rise short; the last rise ends busy
          if (s.cnt + 1'b1 >= target_of(s.job) - 1'b1) begin // [RQ1] [RQ2]
            next_s.state = ST_LATCH; // [RQ3] [RQ4]
          end
        end
      end
      ST_LATCH: begin
        if (mclk_fall) begin
          if (s.job == JOB_CONV) begin
            next_s.result = s.sample; // [RQ6]
          end
          next_s.state = ST_FINISH;
        end
      end
      ST_FINISH: begin
        if (mclk_rise) begin
          next_s.cnt = s.cnt + 1'b1;
          next_s.busy = 1'b0; // [RQ9]
          next_s.state = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= '{state: ST_IDLE, job: JOB_CONV, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign busy_out = s.busy;
  assign result_out = s.result;
  assign full_power_down_out = s.full_pd;
  assign partial_power_down_out = s.part_pd;

  // Independent count of master rises seen while busy
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rise_count <= '0;
    end else if (!busy_out) begin
      rise_count <= '0;
    end else if (mclk_rise) begin
      rise_count <= rise_count + 1'b1;
    end
  end

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);

  a_conv_length: assert property ( // [RQ1]
    $fell(busy_out) && s.job == JOB_CONV |-> rise_count == CONV_PERIODS)
    else $error("conversion length wrong");

  a_cal_full_length: assert property ( // [RQ2]
    $fell(busy_out) && s.job == JOB_CAL_FULL
      |-> rise_count == CAL_FULL_PERIODS)
    else $error("full calibration length wrong");

  a_cal_dac_length: assert property ( // [RQ3]
    $fell(busy_out) && s.job == JOB_CAL_DAC_FS
      |-> rise_count == CAL_DAC_FS_PERIODS)
    else $error("dac full-scale calibration length wrong");

  a_cal_offset_length: assert property ( // [RQ4]
    $fell(busy_out) && s.job == JOB_CAL_OFFSET
      |-> rise_count == CAL_OFFSET_PERIODS)
    else $error("offset calibration length wrong");

  a_cal_busy_rise: assert property ( // [RQ5]
    s.state == ST_IDLE && cal_req && !start_req
      |=> busy_out && s.job != JOB_CONV)
    else $error("busy late after calibration request");

  a_result_before_fall: assert property ( // [RQ6]
    $fell(busy_out) && s.job == JOB_CONV
      |-> $past(s.state == ST_FINISH) && result_out == s.sample)
    else $error("result not ready before busy fell");

  a_result_change_busy: assert property ( // [RQ6]
    $changed(result_out) |-> busy_out && s.state == ST_FINISH)
    else $error("result changed outside latch point");

  a_conv_busy_rise: assert property ( // [RQ7]
    s.state == ST_IDLE && start_req |=> busy_out && s.job == JOB_CONV)
    else $error("start pulse did not raise busy");

  a_power_mode_map: assert property ( // [RQ8]
    ##1 full_power_down_out == $past(pins.pm_hi && !pins.pm_lo) &&
    partial_power_down_out == $past(pins.pm_hi && pins.pm_lo))
    else $error("power-down mode mismatch");

  // The final rise may end busy; every earlier cycle must keep it high
  a_busy_holds: assert property ( // [RQ9]
    busy_out && (rise_count + 1'b1 < target_of(s.job) ||
                 !mclk_rise && rise_count < target_of(s.job))
      |=> busy_out)
    else $error("busy fell before sequence end");

  c_conv_done: cover property (
    $fell(busy_out) && s.job == JOB_CONV);
  c_cal_started: cover property (
    $rose(busy_out) && s.job != JOB_CONV);
  c_partial_pd_start: cover property (
    partial_power_down_out && $rose(busy_out));

endmodule

// file: tb/host_model.sv
`timescale 1ns/10ps

module host_model
  import adc_seq_pkg::*;
#(
  parameter int HALF_NS = 100
) (
  // Bench clock
  input wire logic clock_in,
  // Pins toward the converter
  output logic master_clock_out,
  output logic start_n_out,
  output logic cs_n_out,
  output job_t cal_mode_out
);
  initial begin
    master_clock_out = 1'b0;
    start_n_out = 1'b1;
    cs_n_out = 1'b1;
    cal_mode_out = JOB_CONV;
  end

  // Free-running master clock; its edges coincide with clock_in falling edges
  always #(HALF_NS) master_clock_out = ~master_clock_out;

  // The asserting start edge lands just after a master fall, so no rise is in doubt
  task pulse_start();
    @(negedge master_clock_out);
    @(negedge clock_in);
    start_n_out = 1'b0;
    repeat (10) @(negedge clock_in);
    start_n_out = 1'b1;
  endtask

  task pulse_cs(input job_t j);
    @(negedge clock_in);
    cal_mode_out = j;
    cs_n_out = 1'b0;
    repeat (10) @(negedge clock_in);
    @(negedge master_clock_out);
    @(negedge clock_in);
    cs_n_out = 1'b1;
    repeat (2) @(negedge clock_in);
  endtask
endmodule

// file: tb/tb.sv
`timescale 1ns/10ps
`include "adc_seq_params.svh"

module tb;
  import adc_seq_pkg::*;
  localparam int CONV_N = 18;
  localparam int FULL_N = 5;
  localparam int DAC_N = 4;
  localparam int OFS_N = 3;
  localparam int HALF_NS = 100;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic mclk, start_n, cs_n, busy, full_pd, part_pd;
  logic pm_hi = 1'b0;
  logic pm_lo = 1'b0;
  job_t cal_mode;
  logic [`RESULT_W-1:0] sample = '0;
  logic [`RESULT_W-1:0] result;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;
  int rises = 0;
  time res_t = 0;
  time fall_t = 0;

  always #5 clock_in = ~clock_in;

  host_model #(.HALF_NS(HALF_NS)) i_host_model (
    .clock_in(clock_in),
    .master_clock_out(mclk),
    .start_n_out(start_n),
    .cs_n_out(cs_n),
    .cal_mode_out(cal_mode)
  );

  adc_sequencer #(
    .CONV_PERIODS(17'(CONV_N)),
    .CAL_FULL_PERIODS(17'(FULL_N)),
    .CAL_DAC_FS_PERIODS(17'(DAC_N)),
    .CAL_OFFSET_PERIODS(17'(OFS_N))
  ) i_adc_sequencer (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .master_clock_in(mclk),
    .conversion_start_n_in(start_n),
    .chip_select_n_in(cs_n),
    .cal_mode_in(cal_mode),
    .power_mgmt_bit_hi_in(pm_hi),
    .power_mgmt_bit_lo_in(pm_lo),
    .sample_in(sample),
    .busy_out(busy),
    .result_out(result),
    .full_power_down_out(full_pd),
    .partial_power_down_out(part_pd)
  );

  // Master periods seen while busy is high
  always @(posedge mclk) if (busy === 1'b1) rises++;

  // Times of the last result change and the last busy fall
  always @(result) res_t = $time;
  always @(negedge busy) fall_t = $time;

  function int exp_periods(input job_t j);
    case (j)
      JOB_CAL_FULL: return FULL_N;
      JOB_CAL_DAC_FS: return DAC_N;
      JOB_CAL_OFFSET: return OFS_N;
      default: return CONV_N;
    endcase
  endfunction

  task stop_test();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task check(input bit ok, input string msg);
    check_count++;
    if (!ok) begin
      fails++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task wait_busy(input logic lvl, input int lim, output int n);
    n = 0;
    while (busy !== lvl && n < lim) begin
      @(negedge clock_in);
      n++;
    end
  endtask

  task run_job(input job_t j, input logic [`RESULT_W-1:0] s);
    int n;
    logic [`RESULT_W-1:0] old;
    old = result;
    sample = s;
    rises = 0;
    if (j == JOB_CONV) begin
      i_host_model.pulse_start();
      check(busy === 1'b1, "no busy after start");
    end else begin
      i_host_model.pulse_cs(j);
      wait_busy(1'b1, 48, n);
      check(n < 48, "busy late after cs rise");
    end
    sample = ~s;
    i_host_model.pulse_start();
    wait_busy(1'b0, exp_periods(j) * 20 + 40, n);
    check(rises == exp_periods(j), "length");
    check(result === ((j == JOB_CONV) ? s : old), "wrong result");
    if (j == JOB_CONV)
      check(fall_t - res_t >= HALF_NS, "result late before busy fell");
  endtask

  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      $display("unexpected at %0t: timeout", $time);
      stop_test();
    end
  end

  initial begin
    void'($urandom(32'h2dcf));
    repeat (5) @(negedge clock_in);
    rst_n_in = 1'b1;
    repeat (5) @(negedge clock_in);
    for (int k = 0; k < 4; k++) begin
      pm_hi = k[1];
      pm_lo = k[0];
      repeat (8) @(negedge clock_in);
      check(full_pd === (k == 2), "full power-down");
      check(part_pd === (k == 3), "partial power-down");
      if (k == 2) begin
        i_host_model.pulse_start();
        repeat (20) @(negedge clock_in);
        check(busy === 1'b0, "start taken in power-down");
      end else begin
        run_job(JOB_CONV, `RESULT_W'($urandom));
      end
    end
    pm_hi = 1'b0;
    pm_lo = 1'b0;
    i_host_model.pulse_cs(JOB_CONV);
    repeat (20) @(negedge clock_in);
    check(busy === 1'b0, "cs rise without mode");
    for (int j = 1; j < 4; j++) run_job(job_t'(j), `RESULT_W'($urandom));
    run_job(JOB_CONV, 12'h0fff);
    run_job(JOB_CONV, 12'h0000);
    repeat (3) run_job(JOB_CONV, `RESULT_W'($urandom));
    stop_test();
  end
endmodule
